// [verilog/pmm_top.sv]
// plug-in clock/memory module manager with AXI4-Lite registers
//
// The address map and the AXI4-Lite interface to the registers were chosen for this implementation.
`timescale 1ns/1ps
module pmm_top
    import pmm_pkg::*;
#(
    parameter int SEC_CNT = pmm_pkg::SEC_CYCLES,
    parameter int XFER_CNT = pmm_pkg::XFER_CYCLES,
    parameter int BLINK_CNT = pmm_pkg::BLINK_CYCLES
) (
    input wire logic aclk,
    input wire logic aresetn,
    input pmm_pkg::pmm_axi_req_t axi_req,
    output pmm_pkg::pmm_axi_rsp_t axi_rsp,
    input pmm_pkg::pmm_mod_in_t mod_in,
    output pmm_pkg::pmm_mod_out_t mod_out,
    input wire logic [31:0] ctrl_prog_sig,
    input wire logic proc_fault,
    input wire logic prot_size_match,
    input wire logic prot_type_match,
    output logic run_led,
    output logic dl_protect,
    output logic irq
);
    import pmm_pkg::*;
    // ****************************************
    // functions
    // ****************************************
    function automatic logic is_exec(input pmm_mode_t m);
        is_exec = (m == MD_RUN) || (m == MD_TEST);
    endfunction
    function automatic pmm_mode_t decode_mode(input logic [2:0] c);
        case (c)
            MODE_CODE_RUN: decode_mode = MD_RUN;
            MODE_CODE_TEST: decode_mode = MD_TEST;
            MODE_CODE_SUSP: decode_mode = MD_SUSP;
            default: decode_mode = MD_PROG;
        endcase
    endfunction
    function automatic logic [7:0] days_in(input logic [7:0] mon);
        case (mon)
            FEB: days_in = DAYS_FEB;
            8'h04, 8'h06, 8'h09, 8'h0b: days_in = DAYS_SHORT;
            default: days_in = DAYS_LONG;
        endcase
    endfunction
    function automatic logic stamp_ok(input pmm_date_t d, input pmm_time_t t);
        stamp_ok = (t.sec <= SEC_MAX) && (t.min <= SEC_MAX) && (t.hour <= HOUR_MAX) &&
                   (d.month != 8'h00) && (d.month <= MONTH_MAX) && (d.year <= YEAR_MAX) &&
                   (d.day != 8'h00) && (d.day <= days_in(d.month));
    endfunction
    // ****************************************
    // presence synchroniser
    // ****************************************
    logic present_s;
    pmm_sync u_sync (
        .aclk(aclk),
        .aresetn(aresetn),
        .async_i(mod_in.present),
        .sync_o(present_s)
    );
    // ****************************************
    // AXI4-Lite slave
    // ****************************************
    logic aw_have_q, w_have_q, bvalid_q, rvalid_q;
    logic [7:0] awaddr_q;
    logic [31:0] wdata_q, rdata_q;
    logic [1:0] bresp_q, rresp_q;
    logic [31:0] rd_word;
    logic rd_hit;
    wire aw_take = axi_req.awvalid && !aw_have_q;
    wire w_take = axi_req.wvalid && !w_have_q;
    wire wr_fire = aw_have_q && w_have_q && !bvalid_q;
    wire ar_take = axi_req.arvalid && !rvalid_q;
    wire wr_hit = (awaddr_q == ADDR_CTRL) || (awaddr_q == ADDR_DATE) || (awaddr_q == ADDR_TIME) ||
                  (awaddr_q == ADDR_CMD) || (awaddr_q == ADDR_IRQ_CLR) || (awaddr_q == ADDR_IRQ_EN);
    wire wr_ctrl = wr_fire && (awaddr_q == ADDR_CTRL);
    wire wr_date = wr_fire && (awaddr_q == ADDR_DATE);
    wire wr_time = wr_fire && (awaddr_q == ADDR_TIME);
    wire wr_cmd = wr_fire && (awaddr_q == ADDR_CMD);
    wire wr_clr = wr_fire && (awaddr_q == ADDR_IRQ_CLR);
    wire wr_en = wr_fire && (awaddr_q == ADDR_IRQ_EN);
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_have_q <= 1'b0;
            w_have_q <= 1'b0;
            bvalid_q <= 1'b0;
            rvalid_q <= 1'b0;
            awaddr_q <= 8'h00;
            wdata_q <= 32'h0;
            rdata_q <= 32'h0;
            bresp_q <= RESP_OKAY;
            rresp_q <= RESP_OKAY;
        end else begin
            if (aw_take) begin
                aw_have_q <= 1'b1;
                awaddr_q <= axi_req.awaddr;
            end
            if (w_take) begin
                w_have_q <= 1'b1;
                wdata_q <= axi_req.wdata;
            end
            if (wr_fire) begin
                aw_have_q <= 1'b0;
                w_have_q <= 1'b0;
                bvalid_q <= 1'b1;
                bresp_q <= wr_hit ? RESP_OKAY : RESP_SLVERR;
            end else if (bvalid_q && axi_req.bready) begin
                bvalid_q <= 1'b0;
            end
            if (ar_take) begin
                rvalid_q <= 1'b1;
                rdata_q <= rd_word;
                rresp_q <= rd_hit ? RESP_OKAY : RESP_SLVERR;
            end else if (rvalid_q && axi_req.rready) begin
                rvalid_q <= 1'b0;
            end
        end
    end
    assign axi_rsp.awready = !aw_have_q;
    assign axi_rsp.wready = !w_have_q;
    assign axi_rsp.bvalid = bvalid_q;
    assign axi_rsp.bresp = bresp_q;
    assign axi_rsp.arready = !rvalid_q;
    assign axi_rsp.rvalid = rvalid_q;
    assign axi_rsp.rdata = rdata_q;
    assign axi_rsp.rresp = rresp_q;
    // ****************************************
    // mode control
    // ****************************************
    pmm_mode_t mode_q;
    pmm_xfer_t xf_q;
    logic cmp_en_q, recog_q, init_q;
    logic [2:0] mode_code_q;
    wire pmm_mode_t want_mode = decode_mode(wdata_q[2:0]);
    wire mismatch = recog_q && mod_in.has_memory && (mod_in.prog_sig != ctrl_prog_sig);
    wire cmp_block = wdata_q[CTRL_CMP_EN_BIT] && mismatch;
    wire try_exec = wr_ctrl && !is_exec(mode_q) && is_exec(want_mode) && (xf_q == XF_IDLE);
    wire enter_exec = try_exec && !cmp_block && !proc_fault;
    wire ev_cmp = try_exec && cmp_block;
    wire mode_chg = wr_ctrl && !proc_fault && (!is_exec(want_mode) || enter_exec);
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            mode_q <= MD_PROG;
            mode_code_q <= MODE_CODE_PROG;
            cmp_en_q <= 1'b0;
        end else begin
            if (wr_ctrl) begin
                cmp_en_q <= wdata_q[CTRL_CMP_EN_BIT];
            end
            if (proc_fault) begin
                mode_q <= MD_FAULT;
            end else if (mode_chg) begin
                mode_q <= want_mode;
                mode_code_q <= wdata_q[2:0];
            end
        end
    end
    // ****************************************
    // detection and clock data file
    // ****************************************
    pmm_date_t date_q, stage_q;
    pmm_time_t tod_q;
    logic [CNT_W-1:0] sec_cnt_q;
    // insertion is only looked at outside run/test; run/test entry forces a fresh look
    wire detect = init_q || enter_exec || (!is_exec(mode_q) && present_s && !recog_q);
    wire removed = recog_q && !present_s;
    wire clock_on = recog_q && mod_in.has_clock;
    wire set_ok = wr_time && clock_on && stamp_ok(stage_q, wdata_q[23:0]);
    wire ev_wr_rej = wr_time && !set_ok;
    wire sec_tick = clock_on && (sec_cnt_q == CNT_W'(SEC_CNT - 1));
    wire day_end = (tod_q.sec == SEC_MAX) && (tod_q.min == SEC_MAX) && (tod_q.hour == HOUR_MAX);
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            init_q <= 1'b1;
            recog_q <= 1'b0;
            stage_q <= '0;
        end else begin
            init_q <= 1'b0;
            if (wr_date) begin
                stage_q <= wdata_q[23:0];
            end
            if (removed) begin
                recog_q <= 1'b0;
            end else if (detect) begin
                recog_q <= present_s;
            end
        end
    end
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            date_q <= '0;
            tod_q <= '0;
            sec_cnt_q <= '0;
        end else if (removed && mode_q == MD_RUN) begin
            date_q <= '0;
            tod_q <= '0;
            sec_cnt_q <= '0;
        end else if (detect && present_s && mod_in.has_clock) begin
            date_q <= mod_in.date;
            tod_q <= mod_in.tod;
            sec_cnt_q <= '0;
        end else if (set_ok) begin
            date_q <= stage_q;
            tod_q <= wdata_q[23:0];
            sec_cnt_q <= '0;
        end else if (clock_on) begin
            // battery state does not gate the count while powered
            sec_cnt_q <= sec_tick ? '0 : sec_cnt_q + 1'b1;
            if (sec_tick) begin
                tod_q.sec <= (tod_q.sec == SEC_MAX) ? 8'h00 : tod_q.sec + 8'h01;
                if (tod_q.sec == SEC_MAX) begin
                    tod_q.min <= (tod_q.min == SEC_MAX) ? 8'h00 : tod_q.min + 8'h01;
                end
                if (tod_q.sec == SEC_MAX && tod_q.min == SEC_MAX) begin
                    tod_q.hour <= (tod_q.hour == HOUR_MAX) ? 8'h00 : tod_q.hour + 8'h01;
                end
                if (day_end) begin
                    date_q.day <= (date_q.day >= days_in(date_q.month)) ? 8'h01 : date_q.day + 8'h01;
                end
            end
        end
    end
    wire batt_flag = clock_on && mod_in.batt_low;
    // ****************************************
    // memory module transfers
    // ****************************************
    logic [CNT_W-1:0] xf_cnt_q, blink_cnt_q;
    logic blink_q, led_q, dlp_q;
    logic store_q, load_q, wp_q;
    wire mem_ok = recog_q && mod_in.has_memory && !is_exec(mode_q) && (xf_q == XF_IDLE);
    wire store_req = wr_cmd && wdata_q[CMD_STORE_BIT] && mem_ok;
    wire store_go = store_req && !mod_in.write_protected;
    wire ev_wp_rej = store_req && mod_in.write_protected;
    wire load_go = wr_cmd && !wdata_q[CMD_STORE_BIT] && wdata_q[CMD_LOAD_BIT] && mem_ok;
    wire xf_end = (xf_q != XF_IDLE) && (xf_cnt_q == CNT_W'(XFER_CNT - 1));
    wire ev_done = xf_end;
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            xf_q <= XF_IDLE;
            xf_cnt_q <= '0;
        end else begin
            case (xf_q)
                XF_IDLE: begin
                    xf_cnt_q <= '0;
                    if (store_go) begin
                        xf_q <= XF_STORE;
                    end else if (load_go) begin
                        xf_q <= XF_LOAD;
                    end
                end
                XF_STORE, XF_LOAD: begin
                    xf_cnt_q <= xf_cnt_q + 1'b1;
                    if (xf_end || !present_s) begin
                        xf_q <= XF_IDLE;
                    end
                end
                default: xf_q <= XF_IDLE;
            endcase
        end
    end
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            store_q <= 1'b0;
            load_q <= 1'b0;
            wp_q <= 1'b0;
            dlp_q <= 1'b0;
            blink_cnt_q <= '0;
            blink_q <= 1'b0;
            led_q <= 1'b0;
        end else begin
            // the module keeps a single image, so a store overwrites it
            store_q <= xf_end && (xf_q == XF_STORE);
            load_q <= xf_end && (xf_q == XF_LOAD);
            wp_q <= wr_cmd && wdata_q[CMD_WP_BIT] && mem_ok;
            dlp_q <= (xf_q == XF_LOAD) && !proc_fault && prot_size_match && prot_type_match;
            if (xf_q == XF_IDLE || blink_cnt_q == CNT_W'(BLINK_CNT - 1)) begin
                blink_cnt_q <= '0;
                blink_q <= (xf_q != XF_IDLE) && !blink_q;
            end else begin
                blink_cnt_q <= blink_cnt_q + 1'b1;
            end
            led_q <= (xf_q != XF_IDLE) ? blink_q : is_exec(mode_q);
        end
    end
    assign mod_out.store = store_q;
    assign mod_out.load = load_q;
    assign mod_out.wp_set = wp_q;
    assign mod_out.store_sig = ctrl_prog_sig;
    assign run_led = led_q;
    assign dl_protect = dlp_q;
    // ****************************************
    // interrupts and read mux
    // ****************************************
    logic [IRQ_W-1:0] irq_stat_q, irq_en_q;
    logic irq_q;
    wire [IRQ_W-1:0] ev = {ev_done, ev_wr_rej || ev_wp_rej, ev_cmp, removed};
    wire [IRQ_W-1:0] clr = wr_clr ? wdata_q[IRQ_W-1:0] : '0;
    wire [IRQ_W-1:0] irq_next = (irq_stat_q & ~clr) | ev;
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            irq_stat_q <= '0;
            irq_en_q <= '0;
            irq_q <= 1'b0;
        end else begin
            irq_stat_q <= irq_next; // set beats a same-cycle clear
            if (wr_en) begin
                irq_en_q <= wdata_q[IRQ_W-1:0];
            end
            irq_q <= |(irq_next & (wr_en ? wdata_q[IRQ_W-1:0] : irq_en_q));
        end
    end
    assign irq = irq_q;
    wire [31:0] stat_word = {16'h0, 5'h0, mode_q, mismatch, (xf_q != XF_IDLE), mod_in.write_protected,
                             batt_flag, mod_in.has_memory & recog_q, clock_on, recog_q, present_s};
    assign rd_hit = (axi_req.araddr == ADDR_CTRL) || (axi_req.araddr == ADDR_STAT) ||
                    (axi_req.araddr == ADDR_DATE) || (axi_req.araddr == ADDR_TIME) ||
                    (axi_req.araddr == ADDR_IRQ_STAT) || (axi_req.araddr == ADDR_IRQ_EN);
    always_comb begin
        case (axi_req.araddr)
            ADDR_CTRL: rd_word = {28'h0, cmp_en_q, mode_code_q};
            ADDR_STAT: rd_word = stat_word;
            ADDR_DATE: rd_word = {8'h00, date_q};
            ADDR_TIME: rd_word = {8'h00, tod_q};
            ADDR_IRQ_STAT: rd_word = {28'h0, irq_stat_q};
            ADDR_IRQ_EN: rd_word = {28'h0, irq_en_q};
            default: rd_word = 32'h0;
        endcase
    end
    // ****************************************
    // assertions
    // ****************************************
    run_removal_clears_a: assert property (@(posedge aclk) disable iff (!aresetn)
        (removed && mode_q == MD_RUN) |=> (date_q == '0 && tod_q == '0)) else $error("file not zeroed");
    removal_seen_a: assert property (@(posedge aclk) disable iff (!aresetn)
        (recog_q && !mod_in.present) |-> ##[1:3] !recog_q) else $error("removal missed");
    run_insert_ignored_a: assert property (@(posedge aclk) disable iff (!aresetn)
        (is_exec(mode_q) && !recog_q && !enter_exec) |=> !recog_q) else $error("insert seen in run");
    bad_write_kept_a: assert property (@(posedge aclk) disable iff (!aresetn)
        (ev_wr_rej && !removed && !detect && !sec_tick) |=> ($stable(date_q) && $stable(tod_q)))
        else $error("bad write changed clock");
    good_write_now_a: assert property (@(posedge aclk) disable iff (!aresetn)
        (set_ok && !removed && !detect) |=> (tod_q == $past(wdata_q[23:0]))) else $error("write deferred");
    batt_flag_a: assert property (@(posedge aclk) disable iff (!aresetn)
        !present_s |=> !stat_word[4]) else $error("battery flag without module");
    cmp_block_a: assert property (@(posedge aclk) disable iff (!aresetn)
        ev_cmp |=> !is_exec(mode_q)) else $error("entered run on mismatch");
    wp_store_a: assert property (@(posedge aclk) disable iff (!aresetn)
        ev_wp_rej |=> (xf_q == XF_IDLE) ##1 !store_q) else $error("store on protected module");
    dl_prot_a: assert property (@(posedge aclk) disable iff (!aresetn)
        dl_protect |-> ($past(xf_q) == XF_LOAD && !$past(proc_fault))) else $error("protection bad");
endmodule

// [verilog/pmm_pkg.sv]
// package: register map, field layout, types and timing of the plug-in module manager
package pmm_pkg;
    // ****************************************
    // register map (byte addresses)
    // ****************************************
    localparam logic [7:0] ADDR_CTRL = 8'h00;
    localparam logic [7:0] ADDR_STAT = 8'h04;
    localparam logic [7:0] ADDR_DATE = 8'h08;
    localparam logic [7:0] ADDR_TIME = 8'h0c;
    localparam logic [7:0] ADDR_CMD = 8'h10;
    localparam logic [7:0] ADDR_IRQ_STAT = 8'h14;
    localparam logic [7:0] ADDR_IRQ_CLR = 8'h18;
    localparam logic [7:0] ADDR_IRQ_EN = 8'h1c;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // ****************************************
    // fields
    // ****************************************
    localparam logic [2:0] MODE_CODE_PROG = 3'h0;
    localparam logic [2:0] MODE_CODE_RUN = 3'h1;
    localparam logic [2:0] MODE_CODE_TEST = 3'h2;
    localparam logic [2:0] MODE_CODE_SUSP = 3'h3;
    localparam int CTRL_CMP_EN_BIT = 3;
    localparam int CMD_STORE_BIT = 0;
    localparam int CMD_LOAD_BIT = 1;
    localparam int CMD_WP_BIT = 2;
    localparam int IRQ_REMOVED = 0;
    localparam int IRQ_CMP_REFUSED = 1;
    localparam int IRQ_WR_REJECTED = 2;
    localparam int IRQ_XFER_DONE = 3;
    localparam int IRQ_W = 4;
    localparam logic [7:0] SEC_MAX = 8'h3b;
    localparam logic [7:0] HOUR_MAX = 8'h17;
    localparam logic [7:0] MONTH_MAX = 8'h0c;
    localparam logic [7:0] YEAR_MAX = 8'h63;
    localparam logic [7:0] FEB = 8'h02;
    localparam logic [7:0] DAYS_FEB = 8'h1d;
    localparam logic [7:0] DAYS_SHORT = 8'h1e;
    localparam logic [7:0] DAYS_LONG = 8'h1f;

    // ****************************************
    // timing
    // ****************************************
    localparam int CLK_PERIOD_NS = 50;
    localparam int SEC_NS = 1000000000;
    localparam int SEC_CYCLES = SEC_NS / CLK_PERIOD_NS;
    localparam int XFER_MS = 200;
    localparam int XFER_CYCLES = (XFER_MS * 1000000) / CLK_PERIOD_NS;
    localparam int BLINK_MS = 100;
    localparam int BLINK_CYCLES = (BLINK_MS * 1000000) / CLK_PERIOD_NS;
    localparam int CNT_W = 32;

    // ****************************************
    // types
    // ****************************************
    typedef enum logic [2:0] {MD_PROG, MD_RUN, MD_TEST, MD_SUSP, MD_FAULT} pmm_mode_t;
    typedef enum logic [1:0] {XF_IDLE, XF_STORE, XF_LOAD} pmm_xfer_t;

    // date: [23:16] year, [15:8] month, [7:0] day; time: [23:16] hour, [15:8] min, [7:0] sec
    typedef struct packed {
        logic [7:0] year;
        logic [7:0] month;
        logic [7:0] day;
    } pmm_date_t;
    typedef struct packed {
        logic [7:0] hour;
        logic [7:0] min;
        logic [7:0] sec;
    } pmm_time_t;

    typedef struct packed {
        logic present;
        logic has_clock;
        logic has_memory;
        logic batt_low;
        logic write_protected;
        pmm_date_t date;
        pmm_time_t tod;
        logic [31:0] prog_sig;
    } pmm_mod_in_t;

    typedef struct packed {
        logic store;
        logic load;
        logic wp_set;
        logic [31:0] store_sig;
    } pmm_mod_out_t;

    typedef struct packed {
        logic awvalid;
        logic [7:0] awaddr;
        logic wvalid;
        logic [31:0] wdata;
        logic [3:0] wstrb;
        logic bready;
        logic arvalid;
        logic [7:0] araddr;
        logic rready;
    } pmm_axi_req_t;

    typedef struct packed {
        logic awready;
        logic wready;
        logic bvalid;
        logic [1:0] bresp;
        logic arready;
        logic rvalid;
        logic [31:0] rdata;
        logic [1:0] rresp;
    } pmm_axi_rsp_t;
endpackage

// [verilog/pmm_sync.sv]
// two-flop synchroniser for the module-present level
`timescale 1ns/1ps
module pmm_sync (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic async_i,
    output logic sync_o
);
    logic meta_q;
    logic sync_q;

    // only the second flop is ever read
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            meta_q <= 1'b0;
            sync_q <= 1'b0;
        end else begin
            meta_q <= async_i;
            sync_q <= meta_q;
        end
    end
    assign sync_o = sync_q;
endmodule

// [sim/pmm_mod_model.sv]
// partner model: removable clock and program memory module
`timescale 1ns/1ps
module pmm_mod_model #(
    parameter logic [23:0] START_DATE = 24'h0f0609,
    parameter logic [23:0] START_TOD = 24'h0a1400
) (
    input wire logic aclk,
    input wire logic present_i,
    input wire logic batt_i,
    input pmm_pkg::pmm_mod_out_t mod_out,
    output pmm_pkg::pmm_mod_in_t mod_in,
    output logic [31:0] held_sig
);
    import pmm_pkg::*;
    logic wp_q;
    logic [23:0] junk_q;
    initial begin
        wp_q = 1'b0;
        held_sig = 32'h0;
        junk_q = 24'h5a5a5a;
    end
    // ****************************************
    // module storage
    // ****************************************
    always @(posedge aclk) begin
        junk_q <= ~junk_q;
        if (present_i && mod_out.wp_set)
            wp_q <= 1'b1;
        if (present_i && mod_out.store && !wp_q)
            held_sig <= mod_out.store_sig;
    end
    // absent module: presence, clock, memory and battery lines read low; the rest float, so show a changing pattern, never the old value
    always_comb begin
        mod_in.present = present_i;
        mod_in.has_clock = present_i;
        mod_in.has_memory = present_i;
        mod_in.batt_low = present_i & batt_i;
        mod_in.write_protected = present_i ? wp_q : junk_q[0];
        mod_in.date = present_i ? START_DATE : junk_q;
        mod_in.tod = present_i ? START_TOD : ~junk_q;
        mod_in.prog_sig = present_i ? held_sig : {junk_q[7:0], junk_q};
    end
endmodule

// [sim/pmm_top_bench.sv]
// testbench: bus tasks, expected values and scenarios of the module manager
`timescale 1ns/1ps
module pmm_top_bench;
    import pmm_pkg::*;
    logic aclk, aresetn, pres, batt, fault, szm, tym, led, dlp, irq;
    logic [31:0] csig, held, v;
    pmm_axi_req_t rq;
    pmm_axi_rsp_t rs;
    pmm_mod_in_t mi;
    pmm_mod_out_t mo;
    int error_cnt, tests_run, seed, n, tog;
    logic [47:0] bad[$] = '{48'h140d01000000, 48'h15021e000000, 48'h14041f000000, 48'h640101000000,
        48'h140101180000, 48'h140101003c00, 48'h140001000000};
    logic [3:0] md[$] = '{4'h2, 4'h3, 4'h0, 4'h9};
    pmm_top #(.SEC_CNT(10), .XFER_CNT(20), .BLINK_CNT(3)) dut (.aclk(aclk), .aresetn(aresetn), .axi_req(rq),
        .axi_rsp(rs), .mod_in(mi), .mod_out(mo), .ctrl_prog_sig(csig), .proc_fault(fault),
        .prot_size_match(szm), .prot_type_match(tym), .run_led(led), .dl_protect(dlp), .irq(irq));
    pmm_mod_model mdl (.aclk(aclk), .present_i(pres), .batt_i(batt), .mod_out(mo), .mod_in(mi), .held_sig(held));
    initial begin
        aclk = 1'b0;
        forever #25 aclk = ~aclk;
    end
    task automatic print_verdict;
        if (error_cnt == 0 && tests_run > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        tests_run++;
        if (g !== e) begin
            error_cnt++;
            $display("BAD %s exp %h got %h", nm, e, g);
        end
    endtask
    task automatic tmo;
        if (n >= 300) begin
            chk("timeout", 0, 1);
            print_verdict();
        end
    endtask
    // ready and valid are looked at on the falling edge, so they match what the next rising edge sees
    task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
        logic aw, w, b;
        logic [1:0] r;
        @(posedge aclk);
        rq.awaddr <= a;
        rq.wdata <= d;
        rq.awvalid <= 1'b1;
        rq.wvalid <= 1'b1;
        rq.bready <= 1'b1;
        b = 1'b0;
        for (n = 0; n < 300 && !b; n++) begin
            @(negedge aclk);
            aw = rq.awvalid && rs.awready;
            w = rq.wvalid && rs.wready;
            b = rs.bvalid;
            r = rs.bresp;
            @(posedge aclk);
            if (aw) rq.awvalid <= 1'b0;
            if (w) rq.wvalid <= 1'b0;
        end
        rq.bready <= 1'b0;
        tmo();
        chk("bresp", er, r);
    endtask
    task automatic rc(input string nm, input logic [7:0] a, input logic [1:0] er, input logic [31:0] m,
        input logic [31:0] e);
        logic t, b;
        logic [1:0] r;
        @(posedge aclk);
        rq.araddr <= a;
        rq.arvalid <= 1'b1;
        rq.rready <= 1'b1;
        b = 1'b0;
        for (n = 0; n < 300 && !b; n++) begin
            @(negedge aclk);
            t = rq.arvalid && rs.arready;
            b = rs.rvalid;
            v = rs.rdata;
            r = rs.rresp;
            @(posedge aclk);
            if (t) rq.arvalid <= 1'b0;
        end
        rq.rready <= 1'b0;
        tmo();
        chk("rresp", er, r);
        chk(nm, e, v & m);
    endtask
    task automatic xfer;
        logic p;
        tog = 0;
        p = led;
        for (n = 0; n < 300 && !(mo.store || mo.load); n++) begin
            @(negedge aclk);
            tog += (led !== p);
            p = led;
        end
        tmo();
        @(negedge aclk);
    endtask
    // ****************************************
    // scenarios
    // ****************************************
    initial begin
        seed = 41;
        rq = '0;
        rq.wstrb = 4'hf;
        {aresetn, fault} = 2'b00;
        {pres, batt, szm, tym} = 4'hf;
        csig = $random(seed);
        error_cnt = 0;
        tests_run = 0;
        repeat (4) @(posedge aclk);
        aresetn <= 1'b1;
        repeat (6) @(posedge aclk);
        rc("stat", ADDR_STAT, RESP_OKAY, 32'h1f, 32'h1f);
        rc("date0", ADDR_DATE, RESP_OKAY, 32'hffffff, 32'h0f0609);
        wr(ADDR_DATE, 32'h14021d, RESP_OKAY);
        wr(ADDR_TIME, 32'h0b0500, RESP_OKAY);
        rc("date", ADDR_DATE, RESP_OKAY, 32'hffffff, 32'h14021d);
        rc("time", ADDR_TIME, RESP_OKAY, 32'hffff00, 32'h0b0500);
        repeat (40) @(posedge aclk);
        rc("sec", ADDR_TIME, RESP_OKAY, 32'hffff00, 32'h0b0500);
        chk("sec_runs", 1, v[7:0] != 8'h0);
        wr(ADDR_IRQ_EN, 32'h4, RESP_OKAY);
        rc("irq_en", ADDR_IRQ_EN, RESP_OKAY, 32'hf, 32'h4);
        foreach (bad[i]) begin
            wr(ADDR_DATE, bad[i][47:24], RESP_OKAY);
            wr(ADDR_TIME, bad[i][23:0], RESP_OKAY);
            rc("keep", ADDR_DATE, RESP_OKAY, 32'hffffff, 32'h14021d);
            chk("irq", 1, irq);
            wr(ADDR_IRQ_CLR, 32'h4, RESP_OKAY);
            @(negedge aclk);
            chk("irq_clr", 0, irq);
        end
        wr(ADDR_IRQ_EN, 32'h0, RESP_OKAY);
        wr(ADDR_TIME, 32'h180000, RESP_OKAY);
        @(negedge aclk);
        chk("irq_mask", 0, irq);
        rc("irq_stat", ADDR_IRQ_STAT, RESP_OKAY, 32'h4, 32'h4);
        for (int i = 0; i < 2; i++) begin
            csig <= $random(seed);
            wr(ADDR_CMD, 32'h1, RESP_OKAY);
            xfer();
            chk("blink", 1, tog > 2);
            chk("held", csig, held);
        end
        csig <= ~held;
        wr(ADDR_CTRL, 32'h9, RESP_OKAY);
        rc("refuse", ADDR_STAT, RESP_OKAY, 32'h700, 32'h0);
        rc("irq_cmp", ADDR_IRQ_STAT, RESP_OKAY, 32'h2, 32'h2);
        csig <= held;
        foreach (md[i]) begin
            wr(ADDR_CTRL, md[i], RESP_OKAY);
            rc("mode", ADDR_STAT, RESP_OKAY, 32'h700, {md[i][2:0], 8'h0});
        end
        rc("ctrl", ADDR_CTRL, RESP_OKAY, 32'hf, 32'h9);
        pres <= 1'b0;
        repeat (6) @(posedge aclk);
        rc("date_clr", ADDR_DATE, RESP_OKAY, 32'hffffff, 32'h0);
        rc("time_clr", ADDR_TIME, RESP_OKAY, 32'hffffff, 32'h0);
        rc("batt_gone", ADDR_STAT, RESP_OKAY, 32'h10, 32'h0);
        pres <= 1'b1;
        repeat (6) @(posedge aclk);
        rc("ignored", ADDR_STAT, RESP_OKAY, 32'h2, 32'h0);
        wr(ADDR_CTRL, 32'h0, RESP_OKAY);
        repeat (6) @(posedge aclk);
        rc("seen", ADDR_STAT, RESP_OKAY, 32'h2, 32'h2);
        batt <= 1'b0;
        rc("batt_ok", ADDR_STAT, RESP_OKAY, 32'h1c, 32'h0c);
        for (int i = 0; i < 4; i++) begin
            szm <= i[0];
            tym <= i[1];
            wr(ADDR_CMD, 32'h2, RESP_OKAY);
            repeat (3) @(negedge aclk);
            chk("dl_protect", i == 3, dlp);
            xfer();
        end
        v = held;
        wr(ADDR_CMD, 32'h4, RESP_OKAY);
        repeat (4) @(posedge aclk);
        wr(ADDR_IRQ_CLR, 32'hf, RESP_OKAY);
        csig <= ~v;
        wr(ADDR_CMD, 32'h1, RESP_OKAY);
        repeat (30) @(posedge aclk);
        chk("wp_held", v, held);
        rc("wp_rej", ADDR_IRQ_STAT, RESP_OKAY, 32'h24, 32'h4);
        rc("wp_stat", ADDR_STAT, RESP_OKAY, 32'h20, 32'h20);
        rc("unmapped", 8'h20, RESP_SLVERR, 32'hffffffff, 32'h0);
        wr(ADDR_STAT, 32'h0, RESP_SLVERR);
        fault <= 1'b1;
        rc("fault", ADDR_STAT, RESP_OKAY, 32'h700, 32'h400);
        print_verdict();
    end
endmodule
